// *** pwm_cfg.svh ***
// What this block does
// - Alignment bit clear selects left-aligned waveform for that channel.
// - Left-aligned counter counts up only, from zero to period minus one.
// - Left-aligned: counter equal to duty toggles the output flip-flop.
// - Left-aligned period match clears counter and flip-flop, reloads buffers.
// - Left-aligned output frequency is channel clock over period.
// - High fraction is duty/period, or (period-duty)/period with polarity zero.
// - Alignment bit set selects center-aligned waveform for that channel.
// - Center-aligned counter counts up and down, forced up at zero.
// - Center-aligned period match turns counting from up to down.
// - Center-aligned: duty match toggles flip-flop going up and going down.
// - Center-aligned: down count reaching zero turns up and reloads buffers.
// - Center-aligned period is twice the period value.
// - Four join bits merge pairs 0-1, 2-3, 4-5, 6-7 into 16-bit channels.
// - Even channel holds the high bytes, odd channel the low bytes.
// - Joined channel uses odd channel clock, polarity and output pin.
// - Joined channel runs on odd enable; even enable ignored, even pin off.
// - Any write to either counter byte clears the whole joined counter.
// - Joined channel alignment comes from the odd channel only.
// - Zero duty gives inverse polarity level; duty at/above period gives polarity.
// - Zero period holds counter at zero and output at polarity level.
// - Reset: count up, channels off, clock A for 0,1,4,5, B otherwise.
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// Word indices of the control registers.
`define A_EN       6'h00
`define A_POL      6'h01
`define A_CLK      6'h02
`define A_ALIGN    6'h03
`define A_JOIN     6'h04
// Upper address bits of the per-channel register groups.
`define G_PER      3'h1
`define G_DTY      3'h2
`define G_CNT      3'h3
// Clock choice reset: two bits per channel, 0=A 1=B 2=SA 3=SB.
`define CLK_SEL_RST 16'h5050
`define CLK_SEL_W   2
`define ONE16       16'h0001

`endif

// *** pwm_pkg.sv ***
`default_nettype none

package pwm_pkg;

	// Register bus handshake states, one-hot.
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

	// Live state of one 8-bit channel with its active compare latches.
	typedef struct packed {
		logic [7:0] cnt;
		logic       down;
		logic       ff;
		logic [7:0] per;
		logic [7:0] dty;
	} chan_t;

	// Result of one counting step of a lane, 8 or 16 bits wide.
	typedef struct packed {
		logic [15:0] cnt;
		logic        down;
		logic        ff;
		logic        load;
	} lane_t;

endpackage

`default_nettype wire

// *** pwm_timer.sv ***
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module pwm_timer
	import pwm_pkg::*;
(
	input  wire logic        sys_clk,         // 250 MHz clock.
	input  wire logic        arst_n,          // Async reset, active low.
	input  wire logic [5:0]  avs_address,     // Word address.
	input  wire logic        avs_read,        // Read request.
	input  wire logic        avs_write,       // Write request.
	input  wire logic [31:0] avs_writedata,   // Write data.
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes.
	output var  logic [31:0] avs_readdata,    // Read data.
	output var  logic        avs_waitrequest, // Stall, high while busy.
	input  wire logic [3:0]  clk_ticks,       // Pulses of A, B, SA, SB.
	output var  logic [7:0]  waveform_output  // Channel pins.
);

	////////////////////////////////////////////////////////////////////
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	bus_state_t  bus_q, bus_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wait_q, wait_d;
	logic [7:0]  en_q, en_d, pol_q, pol_d, align_q, align_d;
	logic [15:0] sel_q, sel_d;
	logic [3:0]  join_q, join_d, capv_q, capv_d;
	logic [7:0]  pbuf_q [8];
	logic [7:0]  pbuf_d [8];
	logic [7:0]  dbuf_q [8];
	logic [7:0]  dbuf_d [8];
	logic [7:0]  cap_q [4];
	logic [7:0]  cap_d [4];
	logic [7:0]  cnt_wr;
	chan_t       chan_q [8];
	chan_t       chan_d [8];
	logic [7:0]  pins_q, pins_d;
	logic [15:0] lo_cnt [4];
	logic [15:0] lo_per [4];
	logic [15:0] lo_dty [4];
	logic [3:0]  lo_step, lo_cen, lo_down;

	assign rst_n           = rst_sync_q[1];
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign waveform_output = pins_q;

	// Reset release through two flip-flops.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= '0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus slave: take request, answer one cycle later, apply writes then.
	always_comb begin
		logic [2:0] ch;
		logic [1:0] pr;
		logic       rq;
		ch = avs_address[2:0];
		pr = avs_address[2:1];
		rq = avs_read || avs_write;
		bus_d = bus_q;
		rdata_d = rdata_q;
		en_d = en_q;
		pol_d = pol_q;
		align_d = align_q;
		sel_d = sel_q;
		join_d = join_q;
		pbuf_d = pbuf_q;
		dbuf_d = dbuf_q;
		cap_d = cap_q;
		capv_d = capv_q;
		cnt_wr = '0;
		unique case (bus_q)
			BUS_IDLE: begin
				if (rq) begin
					bus_d = BUS_ACK;
					rdata_d = '0;
					if (avs_read) begin
						unique case (avs_address[5:3])
							`G_PER: rdata_d[7:0] = pbuf_q[ch];
							`G_DTY: rdata_d[7:0] = dbuf_q[ch];
							`G_CNT: begin
								rdata_d[7:0] = chan_q[ch].cnt;
								if (join_q[pr] && !ch[0]) begin
									cap_d[pr] = chan_q[ch + 3'h1].cnt;
									capv_d[pr] = 1'b1;
								end else if (join_q[pr] && capv_q[pr]) begin
									rdata_d[7:0] = cap_q[pr];
									capv_d[pr] = 1'b0;
								end
							end
							default: begin
								unique case (avs_address)
									`A_EN:    rdata_d[7:0] = en_q;
									`A_POL:   rdata_d[7:0] = pol_q;
									`A_CLK:   rdata_d[15:0] = sel_q;
									`A_ALIGN: rdata_d[7:0] = align_q;
									`A_JOIN:  rdata_d[3:0] = join_q;
									default:  rdata_d = '0;
								endcase
							end
						endcase
					end
				end
			end
			BUS_ACK: begin
				bus_d = BUS_IDLE;
				if (avs_write && avs_byteenable[0]) begin
					unique case (avs_address[5:3])
						`G_PER: pbuf_d[ch] = avs_writedata[7:0];
						`G_DTY: dbuf_d[ch] = avs_writedata[7:0];
						`G_CNT: cnt_wr[ch] = 1'b1;
						default: begin
							unique case (avs_address)
								`A_EN:    en_d = avs_writedata[7:0];
								`A_POL:   pol_d = avs_writedata[7:0];
								`A_CLK:   sel_d[7:0] = avs_writedata[7:0];
								`A_ALIGN: align_d = avs_writedata[7:0];
								`A_JOIN:  join_d = avs_writedata[3:0];
								default:  ;
							endcase
						end
					endcase
				end
				if (avs_write && avs_byteenable[1] && avs_address == `A_CLK) begin
					sel_d[15:8] = avs_writedata[15:8];
				end
			end
		endcase
		wait_d = (bus_d != BUS_ACK);
	end

	// Bus and configuration registers.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= BUS_IDLE;
			rdata_q <= '0;
			wait_q <= 1'b1;
			en_q <= '0;
			pol_q <= '0;
			align_q <= '0;
			sel_q <= `CLK_SEL_RST;
			join_q <= '0;
			pbuf_q <= '{default: '0};
			dbuf_q <= '{default: '0};
			cap_q <= '{default: '0};
			capv_q <= '0;
		end else begin
			bus_q <= bus_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			en_q <= en_d;
			pol_q <= pol_d;
			align_q <= align_d;
			sel_q <= sel_d;
			join_q <= join_d;
			pbuf_q <= pbuf_d;
			dbuf_q <= dbuf_d;
			cap_q <= cap_d;
			capv_q <= capv_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// One counting step of a lane in left or center alignment.
	function automatic lane_t step_lane(
		input logic [15:0] cnt,
		input logic [15:0] per,
		input logic [15:0] dty,
		input logic        cen,
		input logic        down,
		input logic        ff
	);
		lane_t       r;
		logic        dn;
		logic [15:0] nx;
		// Left alignment never counts down, even right after a center run.
		dn = down && (cnt != '0) && cen;
		nx = dn ? cnt - `ONE16 : cnt + `ONE16;
		r.cnt = cnt;
		r.down = dn;
		r.ff = ff;
		r.load = 1'b0;
		if (per == '0) begin
			r.cnt = '0;
			r.down = 1'b0;
			r.ff = 1'b0;
		end else if (!cen) begin
			if (nx >= per) begin
				r.cnt = '0;
				r.ff = 1'b0;
				r.load = 1'b1;
			end else begin
				r.cnt = nx;
				r.ff = (nx == dty) ? !ff : ff;
			end
		end else begin
			r.cnt = nx;
			r.ff = (nx == dty) ? !ff : ff;
			if (!dn && nx >= per) begin
				r.down = 1'b1;
			end
			if (dn && nx == '0) begin
				r.down = 1'b0;
				r.ff = 1'b0;
				r.load = 1'b1;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Channel lanes: the odd lane of a joined pair runs 16 bits wide.
	always_comb begin
		int          c;
		int          h;
		logic        solo, en, wr, step, pol, load, lvl;
		logic [15:0] cnt16, per16, dty16;
		lane_t       nl;
		c = 0;
		h = 0;
		solo = 1'b0;
		en = 1'b0;
		wr = 1'b0;
		step = 1'b0;
		pol = 1'b0;
		load = 1'b0;
		lvl = 1'b0;
		cnt16 = '0;
		per16 = '0;
		dty16 = '0;
		nl = '0;
		chan_d = chan_q;
		pins_d = '0;
		lo_cnt = '{default: '0};
		lo_per = '{default: '0};
		lo_dty = '{default: '0};
		lo_step = '0;
		lo_cen = '0;
		lo_down = '0;
		for (int p = 0; p < 4; p++) begin
			for (int l = 0; l < 2; l++) begin
				c = 2 * p + l;
				h = 2 * p;
				solo = !join_q[p];
				if (solo || l == 1) begin
					cnt16 = solo ? {8'h00, chan_q[c].cnt}
					             : {chan_q[h].cnt, chan_q[c].cnt};
					per16 = solo ? {8'h00, chan_q[c].per}
					             : {chan_q[h].per, chan_q[c].per};
					dty16 = solo ? {8'h00, chan_q[c].dty}
					             : {chan_q[h].dty, chan_q[c].dty};
					en = en_q[c];
					pol = pol_q[c];
					wr = cnt_wr[c] || (!solo && cnt_wr[h]);
					step = clk_ticks[sel_q[`CLK_SEL_W*c +: `CLK_SEL_W]]
					    && (en || per16 == '0) && !wr;
					nl = step_lane(cnt16, per16, dty16, align_q[c],
					               chan_q[c].down, chan_q[c].ff);
					if (wr) begin
						nl = '0;
						nl.load = 1'b1;
					end else if (!step) begin
						nl.cnt = cnt16;
						nl.down = chan_q[c].down;
						nl.ff = chan_q[c].ff;
						nl.load = 1'b0;
					end
					load = nl.load || !en;
					chan_d[c].cnt = nl.cnt[7:0];
					chan_d[c].down = nl.down;
					chan_d[c].ff = nl.ff;
					if (load) begin
						chan_d[c].per = pbuf_q[c];
						chan_d[c].dty = dbuf_q[c];
					end
					if (!solo) begin
						chan_d[h].cnt = nl.cnt[15:8];
						if (load) begin
							chan_d[h].per = pbuf_q[h];
							chan_d[h].dty = dbuf_q[h];
						end
					end
					if (per16 == '0) begin
						lvl = pol;
					end else if (dty16 == '0) begin
						lvl = !pol;
					end else if (dty16 >= per16) begin
						lvl = pol;
					end else begin
						lvl = chan_q[c].ff ^ pol;
					end
					pins_d[c] = en && lvl;
					if (l == 1) begin
						lo_cnt[p] = cnt16;
						lo_per[p] = per16;
						lo_dty[p] = dty16;
						lo_step[p] = step;
						lo_cen[p] = align_q[c];
						lo_down[p] = chan_q[c].down;
					end
				end
			end
		end
	end

	// Channel counters, latches and pins.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_q <= '{default: '0};
			pins_q <= '0;
		end else begin
			chan_q <= chan_d;
			pins_q <= pins_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the handshake, on lane 1, the low lane of pair 0, and on the pin of lane 0.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	bus_answer_a: assert property ((avs_read || avs_write) && wait_q
		|=> !wait_q) else $error("bus answer late");
	left_count_a: assert property (
		lo_step[0] && !lo_cen[0] && lo_cnt[0] + `ONE16 < lo_per[0]
		|=> lo_cnt[0] == $past(lo_cnt[0]) + `ONE16)
		else $error("left count did not step");
	left_wrap_a: assert property (
		lo_step[0] && !lo_cen[0] && lo_per[0] != '0
		&& lo_cnt[0] + `ONE16 >= lo_per[0] |=> lo_cnt[0] == '0)
		else $error("left count did not wrap");
	center_zero_a: assert property (
		lo_step[0] && lo_cen[0] && lo_cnt[0] == '0 && lo_per[0] != '0
		|=> lo_cnt[0] == `ONE16) else $error("zero did not count up");
	center_peak_a: assert property (
		lo_step[0] && lo_cen[0] && !lo_down[0] && lo_cnt[0] != '0
		&& lo_cnt[0] + `ONE16 == lo_per[0] |=> lo_down[0])
		else $error("peak did not turn down");
	center_floor_a: assert property (
		lo_step[0] && lo_cen[0] && lo_down[0] && lo_cnt[0] == `ONE16
		|=> !lo_down[0] && lo_cnt[0] == '0)
		else $error("floor did not turn up");
	joined_clear_a: assert property (
		(cnt_wr[0] || cnt_wr[1]) && join_q[0] |=> lo_cnt[0] == '0)
		else $error("joined counter not cleared");
	no_period_a: assert property (
		en_q[1] && lo_per[0] == '0 |=> pins_q[1] == $past(pol_q[1]))
		else $error("zero period level wrong");
	no_duty_a: assert property (
		en_q[1] && lo_per[0] != '0 && lo_dty[0] == '0
		|=> pins_q[1] == !$past(pol_q[1])) else $error("zero duty level wrong");
	high_off_a: assert property (join_q[0] |=> !pins_q[0])
		else $error("high pin of joined pair driven");
	left_up_a: assert property (
		lo_step[0] && !lo_cen[0] |=> !lo_down[0])
		else $error("left count turned down");

	cover property (lo_step[0] && lo_cen[0] && lo_down[0]
		&& lo_cnt[0] == `ONE16);
	cover property (lo_step[0] && !lo_cen[0] && lo_cnt[0] + `ONE16 == lo_per[0]);
	cover property (join_q[0] && cnt_wr[0]);
	cover property (capv_q[0] && avs_read && !wait_q);
	cover property (en_q[1] && lo_per[0] == '0);

endmodule

`default_nettype wire

// *** tb_pwm_channel_alignment_concat.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module tb_pwm_channel_alignment_concat import pwm_pkg::*;;
	logic        sys_clk;
	logic        arst_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  clk_ticks;
	logic [7:0]  waveform_output;
	int          fail_count;
	int          compares;
	int          cycles;
	logic [7:0]  b_per [6] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h04, 8'h04};
	logic [7:0]  b_dty [6] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h04, 8'h05};
	logic        b_pol [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic        b_all [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	pwm_timer uut (
		.sys_clk         (sys_clk),
		.arst_n          (arst_n),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.clk_ticks       (clk_ticks),
		.waveform_output (waveform_output)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-running 250 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Cuts a hung run short.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			$display("[FAIL] %0t timeout", $time);
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Avalon write, held until waitrequest is seen low.
	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Avalon read; data is taken at the edge that sees waitrequest low.
	task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Programs one channel while stopped, clears its counter, enables.
	task automatic run(input int ch, input logic [7:0] per, dty, pol, aln,
		en);
		bus_wr(`A_EN, 32'h0);
		bus_wr({`G_PER, ch[2:0]}, {24'h0, per});
		bus_wr({`G_DTY, ch[2:0]}, {24'h0, dty});
		bus_wr(`A_POL, {24'h0, pol});
		bus_wr(`A_ALIGN, {24'h0, aln});
		bus_wr({`G_CNT, ch[2:0]}, 32'h0);
		bus_wr(`A_EN, {24'h0, en});
	endtask

	// Counts high samples over n cycles and rising edges over n steps.
	task automatic measure(input int ch, n, output int hi, ed);
		logic prev;
		hi = 0;
		ed = 0;
		@(posedge sys_clk);
		prev = waveform_output[ch];
		for (int i = 0; i < n; i++) begin
			if (prev === 1'b1) hi++;
			@(posedge sys_clk);
			if (prev === 1'b0 && waveform_output[ch] === 1'b1) ed++;
			prev = waveform_output[ch];
		end
	endtask

	// Largest of eight counter reads, spaced to cover every phase.
	task automatic max_cnt(input logic [5:0] a, output logic [31:0] mx);
		logic [31:0] v;
		mx = 0;
		for (int i = 0; i < 8; i++) begin
			bus_rd(a, v);
			if (v > mx) mx = v;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset values and a stopped, disabled channel.
	task automatic test_reset();
		logic [31:0] v;
		bus_rd(`A_CLK, v);
		chk(v, 32'h5050, "clock choice reset");
		bus_rd(`A_EN, v);
		chk(v, 32'h0, "enable reset");
		bus_rd(6'h3f, v);
		chk(v, 32'h0, "unmapped read");
		bus_wr(6'h08, 32'h04);
		repeat (10) @(posedge sys_clk);
		bus_rd(6'h18, v);
		chk(v, 32'h0, "disabled counter moved");
		chk({24'h0, waveform_output}, 32'h0, "pins at reset");
	endtask

	// Left-aligned waveform, both polarities, buffered period reload.
	task automatic test_left();
		logic [31:0] v;
		int          hi;
		int          ed;
		run(0, 8'h04, 8'h01, 8'h00, 8'h00, 8'h01);
		repeat (12) @(posedge sys_clk);
		measure(0, 40, hi, ed);
		chk(hi, 30, "left high time");
		chk(ed, 10, "left frequency");
		max_cnt(6'h18, v);
		chk(v, 32'h3, "left counter peak");
		run(0, 8'h04, 8'h01, 8'h01, 8'h00, 8'h01);
		repeat (12) @(posedge sys_clk);
		measure(0, 40, hi, ed);
		chk(hi, 10, "left high time pol1");
		bus_wr(6'h08, 32'h08);
		repeat (16) @(posedge sys_clk);
		measure(0, 40, hi, ed);
		chk(ed, 5, "reloaded period");
	endtask

	// Center-aligned waveform on a clock B channel.
	task automatic test_center();
		logic [31:0] v;
		int          hi;
		int          ed;
		run(2, 8'h04, 8'h01, 8'h00, 8'h04, 8'h04);
		repeat (16) @(posedge sys_clk);
		measure(2, 40, hi, ed);
		chk(hi, 30, "center high time");
		chk(ed, 5, "center frequency");
		max_cnt(6'h1a, v);
		chk(v, 32'h4, "center counter peak");
	endtask

	// Boundary duty and period values in both modes.
	task automatic test_bound();
		int hi;
		int ed;
		for (int i = 0; i < 6; i++) begin
			run(1, b_per[i], b_dty[i], {6'h0, b_pol[i], 1'h0},
				{6'h0, i[0], 1'h0}, 8'h02);
			repeat (12) @(posedge sys_clk);
			measure(1, 16, hi, ed);
			chk(hi, b_all[i] ? 16 : 0, "boundary level");
		end
	endtask

	// Joined pair 0-1: bytes, controls, pins, counter clear and read.
	task automatic test_join();
		logic [31:0] h;
		logic [31:0] l;
		int          hi;
		int          ed;
		bus_wr(`A_EN, 32'h0);
		bus_wr(`A_JOIN, 32'h1);
		bus_wr(`A_CLK, 32'h5053);
		clk_ticks <= 4'h3;
		bus_wr(6'h08, 32'h01);
		bus_wr(6'h10, 32'h00);
		run(1, 8'h00, 8'h40, 8'h02, 8'h01, 8'h03);
		repeat (600) @(posedge sys_clk);
		measure(1, 512, hi, ed);
		chk(hi, 128, "joined high time");
		chk(ed, 2, "joined clock and pin");
		measure(0, 64, hi, ed);
		chk(hi, 0, "high pin of pair");
		bus_wr(`A_ALIGN, 32'h02);
		repeat (1100) @(posedge sys_clk);
		measure(1, 1024, hi, ed);
		chk(hi, 256, "joined center high");
		chk(ed, 2, "joined center freq");
		clk_ticks <= 4'h0;
		bus_wr(6'h19, 32'h0);
		bus_rd(6'h18, h);
		bus_rd(6'h19, l);
		chk({h[7:0], l[7:0]}, 32'h0, "low byte write clear");
		clk_ticks <= 4'h3;
		repeat (40) @(posedge sys_clk);
		bus_rd(6'h18, h);
		bus_rd(6'h19, l);
		chk({h[7:0], l[7:0]}, 32'h28, "joined count");
		clk_ticks <= 4'h0;
		bus_wr(6'h18, 32'h0);
		bus_rd(6'h18, h);
		bus_rd(6'h19, l);
		chk({h[7:0], l[7:0]}, 32'h0, "high byte write clear");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset through 20 cycles, then every scenario in turn.
	initial begin
		arst_n         = 1'b0;
		avs_address    = 6'h0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
		clk_ticks      = 4'hf;
		fail_count     = 0;
		compares       = 0;
		cycles         = 0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		test_reset();
		test_left();
		test_center();
		test_bound();
		test_join();
		give_verdict();
	end
endmodule

`default_nettype wire
